// file: bench/periph_idle_monitor.sv
// Purpose: Port checker for the peripheral idle gating block.
// Assumes: Control and request bits are shadowed from observed APB writes.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module periph_idle_monitor
    import periph_idle_pkg::*;
#(
    parameter int unsigned GATES = 14
)(
    // Clock and reset.
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave.
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Idle and gates.
    input wire logic              idle_exec,
    input wire gate_vec_t         gates,
    input wire logic              periph_domain_idle_flag
);
    logic [15:0] ctrl_q;
    logic        req_q;
    wire logic   wr_hit = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 16'h0000;
            req_q  <= 1'b0;
        end else if (wr_hit && paddr == GATE_CTRL_ADDR) begin
            if (pstrb[0]) ctrl_q[7:0] <= pwdata[7:0];
            if (pstrb[1]) ctrl_q[15:8] <= pwdata[15:8];
        end else if (wr_hit && paddr == IDLE_CTRL_ADDR && pstrb[0]) begin
            req_q <= pwdata[3];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_idle_on; idle_exec && req_q; endsequence
    sequence s_idle_off; idle_exec && !req_q; endsequence
    property p_misc; s_idle_on |=> gates.misc_gate == $past(ctrl_q[13]); endproperty
    a_misc: assert property (p_misc) else $error("misc gate wrong");
    property p_ext; s_idle_on |=> gates.ext_mem_if_gate == $past(ctrl_q[12]); endproperty
    a_ext: assert property (p_ext) else $error("memory gate wrong");
    property p_ost; s_idle_on |=> gates.os_timer_gate == $past(ctrl_q[11]); endproperty
    a_ost: assert property (p_ost) else $error("os timer gate wrong");
    property p_wdog; s_idle_on |=> gates.watchdog_gate == $past(ctrl_q[10]); endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog gate wrong");
    property p_par; s_idle_on |=> gates.parallel_port_gate == $past(ctrl_q[9]); endproperty
    a_par: assert property (p_par) else $error("parallel gate wrong");
    property p_low; s_idle_on |=> gates[8:0] == ($past(ctrl_q[8:0]) & 9'h1EF); endproperty
    a_low: assert property (p_low) else $error("low gates wrong");
    property p_wake; s_idle_off |=> gates == 14'h0000 && !periph_domain_idle_flag; endproperty
    a_wake: assert property (p_wake) else $error("wake incomplete");
    property p_hold; !idle_exec |=> $stable(gates); endproperty
    a_hold: assert property (p_hold) else $error("gates moved without idle");
    property p_flag; idle_exec |=> periph_domain_idle_flag == $past(req_q); endproperty
    a_flag: assert property (p_flag) else $error("idle flag wrong");
    property p_rsv; psel && penable && !pwrite && paddr == GATE_CTRL_ADDR
        |-> prdata[31:14] == 18'h00000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind periph_idle_gating periph_idle_monitor #(.GATES(GATES)) periph_idle_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_exec(idle_exec), .gates(gates),
    .periph_domain_idle_flag(periph_domain_idle_flag));

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the peripheral idle gating block.
// Assumes: APB master tasks; idle instruction modelled as a one-cycle pulse.
// Notes:   One scenario writes the upper byte lane alone.
`timescale 1ns/1ps
module tb_top
    import periph_idle_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hF;
    logic        idle_exec = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    gate_vec_t   gates;
    logic        flag;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          samples_checked = 0;
    always #10 pclk = ~pclk;
    periph_idle_gating #(.GATES(14)) periph_idle_gating_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_exec(idle_exec), .gates(gates),
        .periph_domain_idle_flag(flag));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d, samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        @(posedge pclk);
        idle_exec <= 1'b1;
        @(posedge pclk);
        idle_exec <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, GATE_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000_0000);
        xfer(1'b1, GATE_CTRL_ADDR, 32'hFFFF_FFFF);
        xfer(1'b0, GATE_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000_3FFF);
        chk({18'h0, gates}, 32'h0000_0000);
        xfer(1'b1, IDLE_CTRL_ADDR, 32'h0000_0008);
        idle();
        chk({18'h0, gates}, 32'h0000_3FEF);
        chk({31'h0, flag}, 32'h0000_0001);
        // The gate status word is read-only: this write must not disturb it.
        xfer(1'b1, GATE_STAT_ADDR, 32'h0000_0000);
        xfer(1'b0, GATE_STAT_ADDR, 32'h0);
        chk(rd, 32'h0000_3FEF);
        xfer(1'b1, IDLE_CTRL_ADDR, 32'h0);
        idle();
        chk({18'h0, gates}, 32'h0000_0000);
        chk({31'h0, flag}, 32'h0000_0000);
        xfer(1'b1, IDLE_CTRL_ADDR, 32'h0000_0008);
        for (int i = 0; i < 14; i++) begin
            xfer(1'b1, GATE_CTRL_ADDR, 32'h1 << i);
            idle();
            chk({18'h0, gates}, (32'h1 << i) & 32'h3FEF);
        end
        // Upper lane alone: the low byte keeps its value and bits 15..14 stay zero.
        pstrb <= 4'h2;
        xfer(1'b1, GATE_CTRL_ADDR, 32'h0000_CFFF);
        pstrb <= 4'hF;
        xfer(1'b0, GATE_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0000_0F00);
        idle();
        chk({18'h0, gates}, 32'h0000_0F00);
        xfer(1'b0, 18'h00010, 32'h0);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        end_sim();
    end
    initial begin
        #100us;
        errors++;
        end_sim();
    end
endmodule

// file: hw/periph_gate_cell.sv
// Purpose: One peripheral's idle gate, updated on each idle instruction.
// Assumes: idle_exec is a one-cycle pulse.
// Notes:   Disabled state is held until the next idle instruction decides again.
`timescale 1ns/1ps
module periph_gate_cell
    import periph_idle_pkg::*;
(
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Decision inputs.
    input  wire logic idle_exec,
    input  wire logic idle_request,
    input  wire logic ctrl_bit,
    // Gate output.
    output logic      gated
);

    logic gated_q;
    logic gated_d;

    always_comb begin
        gated_d = gated_q;
        if (idle_exec) begin
            // Request low wakes every peripheral whatever its bit says.
            if (!idle_request) begin
                gated_d = 1'b0; // [R7]
            end else begin
                gated_d = ctrl_bit; // [R8]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_q <= 1'b0;
        end else begin
            gated_q <= gated_d;
        end
    end

    assign gated = gated_q;

endmodule

// file: hw/periph_idle_gating.sv
// Purpose: Peripheral idle control register and per-peripheral idle gating.
// Assumes: APB slave, zero wait states; idle_exec pulses once per idle instruction.
// Notes:   Gates are held from flip-flops; a gate high means that peripheral is disabled.
//
// Contract
// [R1] Control bit 13 disables the miscellaneous configuration group on idle when set.
// [R2] Misc gate: bus select, timeout error, bus control, timer select, clock-out, clock mode.
// [R3] Control bit 12 disables the external memory interface on idle when set.
// [R4] Control bit 11 disables the OS timer on idle when set.
// [R5] Control bit 10 disables the watchdog on idle when set.
// [R6] Control bit 9 disables the parallel port on idle when set.
// [R7] An idle instruction with the request low wakes every peripheral, whatever the control bits.
// [R8] With the request high, an idle instruction wakes peripherals whose bit is 0 only.
// [R9] Bits 8..5, 3..0 gate UART, I2C, ident, GPIO, serial ports, timers; bit 4 is reserved.
// [R10] Status bit 3 reads 1 while the peripheral domain is disabled and 0 while active; the code reads back the written request bit instead.
// [R11] Bits 15 and 14 ignore writes and read zero, and every control bit resets to zero.
`timescale 1ns/1ps
module periph_idle_gating
    import periph_idle_pkg::*;
#(
    parameter int unsigned GATES = 14
)(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Processor idle instruction.
    input  wire logic              idle_exec,
    // Peripheral gates.
    output gate_vec_t              gates,
    output logic                   periph_domain_idle_flag
);

    // Refuse a gate count that the fixed field layout cannot serve.
    generate
        if (GATES != 14) begin : gen_bad_gates
            $error("periph_idle_gating supports exactly 14 gate positions");
        end
    endgenerate

    // Register state.
    logic [15:0]   peripheral_idle_control_q;
    logic [15:0]   peripheral_idle_control_d;
    logic [15:0]   idle_status_reg_q;
    logic [15:0]   idle_status_reg_d;
    domain_state_t domain_q;
    domain_state_t domain_d;
    logic [31:0]   prdata_q;
    logic [31:0]   prdata_d;
    logic          pslverr_q;
    logic          pslverr_d;
    // Bus decode.
    logic          access;
    logic          setup;
    logic          sel_ctrl;
    logic          sel_gate_stat;
    logic          sel_idle_req;
    logic          addr_ok;
    logic          wr_ctrl;
    logic          wr_idle_req;
    logic [15:0]   wmask;
    logic [15:0]   ctrl_wr_mask;
    logic [15:0]   read_word;
    // Gating.
    logic [15:0]   gate_bits;
    logic [15:0]   gate_state;
    logic          periph_domain_idle_request;

    assign access        = psel && penable;
    assign setup         = psel && !penable;
    assign sel_ctrl      = (paddr == GATE_CTRL_ADDR);
    assign sel_gate_stat = (paddr == GATE_STAT_ADDR);
    assign sel_idle_req  = (paddr == IDLE_CTRL_ADDR);
    assign addr_ok       = sel_ctrl || sel_gate_stat || sel_idle_req;
    assign wr_ctrl       = access && pwrite && sel_ctrl;
    assign wr_idle_req   = access && pwrite && sel_idle_req && pstrb[0];
    assign wmask         = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign ctrl_wr_mask  = wmask & GATE_CTRL_WR_MASK; // [R11]
    assign periph_domain_idle_request = idle_status_reg_q[BIT_IDLE_REQ];

    // Control register: a write lands at the access edge, lane by lane.
    always_comb begin
        peripheral_idle_control_d = peripheral_idle_control_q;
        if (wr_ctrl) begin
            peripheral_idle_control_d = (peripheral_idle_control_q & ~ctrl_wr_mask)
                | (pwdata[15:0] & ctrl_wr_mask); // [R11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_idle_control_q <= GATE_CTRL_RESET; // [R11]
        end else begin
            peripheral_idle_control_q <= peripheral_idle_control_d;
        end
    end

    // Idle request register: only the request bit is writable.
    always_comb begin
        idle_status_reg_d = idle_status_reg_q;
        if (wr_idle_req) begin
            idle_status_reg_d[BIT_IDLE_REQ] = pwdata[BIT_IDLE_REQ];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_status_reg_q <= IDLE_CTRL_RESET;
        end else begin
            idle_status_reg_q <= idle_status_reg_d;
        end
    end

    // Word to be read at the current address; unmapped addresses read zero.
    always_comb begin
        read_word = 16'h0000;
        case (paddr)
            GATE_CTRL_ADDR: begin
                read_word = peripheral_idle_control_q & GATE_CTRL_WR_MASK; // [R11]
            end
            GATE_STAT_ADDR: begin
                read_word = gate_state;
            end
            IDLE_CTRL_ADDR: begin
                read_word = idle_status_reg_q;
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
    end

    // Read data is loaded in the setup cycle and held through the access cycle.
    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = RDATA_ZERO;
            if (!pwrite) begin
                prdata_d = {16'h0000, read_word};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= RDATA_ZERO;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // Error is decided in the setup cycle and shown only in the access cycle.
    always_comb begin
        pslverr_d = pslverr_q;
        if (setup) begin
            pslverr_d = !addr_ok;
        end else if (!access) begin
            pslverr_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= pslverr_d;
        end
    end

    // Domain idle state follows the last idle instruction.
    always_comb begin
        domain_d = domain_q;
        if (idle_exec) begin
            case (periph_domain_idle_request)
                1'b0: domain_d = DOMAIN_ACTIVE; // [R7]
                1'b1: domain_d = DOMAIN_IDLE; // [R8]
                default: domain_d = DOMAIN_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            domain_q <= DOMAIN_ACTIVE;
        end else begin
            domain_q <= domain_d;
        end
    end

    // Reserved bit 4 never gates anything.
    assign gate_bits = peripheral_idle_control_q & GATE_CTRL_USE_MASK; // [R9]

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : gen_gate
            if (g < GATES && g != BIT_RESERVED4) begin : gen_cell
                periph_gate_cell u_cell (
                    .pclk         (pclk),
                    .presetn      (presetn),
                    .idle_exec    (idle_exec),
                    .idle_request (periph_domain_idle_request),
                    .ctrl_bit     (gate_bits[g]),
                    .gated        (gate_state[g])
                );
            end else begin : gen_none
                assign gate_state[g] = 1'b0;
            end
        end
    endgenerate

    // Misc gate drives the bus selection, timeout, bus control, timer select,
    // clock-out and clock mode registers together.
    assign gates.misc_gate          = gate_state[BIT_MISC]; // [R1] [R2]
    assign gates.ext_mem_if_gate    = gate_state[BIT_EXT_MEM]; // [R3]
    assign gates.os_timer_gate      = gate_state[BIT_OS_TIMER]; // [R4]
    assign gates.watchdog_gate      = gate_state[BIT_WATCHDOG]; // [R5]
    assign gates.parallel_port_gate = gate_state[BIT_PARALLEL]; // [R6]
    assign gates.serial_uart_gate   = gate_state[BIT_UART]; // [R9]
    assign gates.i2c_gate           = gate_state[BIT_I2C];
    assign gates.ident_module_gate  = gate_state[BIT_IDENT];
    assign gates.gpio_gate          = gate_state[BIT_GPIO];
    assign gates.reserved_gate      = gate_state[BIT_RESERVED4];
    assign gates.serial_port_b_gate = gate_state[BIT_SPORT_B];
    assign gates.serial_port_a_gate = gate_state[BIT_SPORT_A];
    assign gates.timer_b_gate       = gate_state[BIT_TIMER_B];
    assign gates.timer_a_gate       = gate_state[BIT_TIMER_A];

    assign periph_domain_idle_flag = (domain_q == DOMAIN_IDLE); // [R10]
    assign prdata  = prdata_q;
    assign pready  = access;
    assign pslverr = access && pslverr_q;

endmodule

// file: hw/periph_idle_pkg.sv
// Purpose: Shared constants and types for the peripheral idle gating block.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Offsets 0x9400 to 0x9402 are word indices; byte address is index times four.
package periph_idle_pkg;

    localparam int unsigned  APB_AW             = 18;
    localparam logic [15:0]  GATE_CTRL_INDEX    = 16'h9400;
    localparam logic [15:0]  GATE_STAT_INDEX    = 16'h9401;
    localparam logic [15:0]  IDLE_CTRL_INDEX    = 16'h9402;
    localparam logic [17:0]  GATE_CTRL_ADDR     = {GATE_CTRL_INDEX, 2'b00};
    localparam logic [17:0]  GATE_STAT_ADDR     = {GATE_STAT_INDEX, 2'b00};
    localparam logic [17:0]  IDLE_CTRL_ADDR     = {IDLE_CTRL_INDEX, 2'b00};

    // Control register field positions; BIT_IDLE_REQ is the request bit of the idle request register.
    localparam int unsigned  BIT_TIMER_A        = 0;
    localparam int unsigned  BIT_TIMER_B        = 1;
    localparam int unsigned  BIT_SPORT_A        = 2;
    localparam int unsigned  BIT_SPORT_B        = 3;
    localparam int unsigned  BIT_RESERVED4      = 4;
    localparam int unsigned  BIT_GPIO           = 5;
    localparam int unsigned  BIT_IDENT          = 6;
    localparam int unsigned  BIT_I2C            = 7;
    localparam int unsigned  BIT_UART           = 8;
    localparam int unsigned  BIT_PARALLEL       = 9;
    localparam int unsigned  BIT_WATCHDOG       = 10;
    localparam int unsigned  BIT_OS_TIMER       = 11;
    localparam int unsigned  BIT_EXT_MEM        = 12;
    localparam int unsigned  BIT_MISC           = 13;
    localparam int unsigned  BIT_IDLE_REQ       = 3;

    // Writable control bits: 13..0 including reserved bit 4; 15..14 are read-only zero.
    localparam logic [15:0]  GATE_CTRL_WR_MASK  = 16'h3FFF;
    localparam logic [15:0]  GATE_CTRL_USE_MASK = 16'h3FEF;
    localparam logic [15:0]  GATE_CTRL_RESET    = 16'h0000;
    localparam logic [15:0]  IDLE_CTRL_RESET    = 16'h0000;
    localparam logic [31:0]  RDATA_ZERO         = 32'h0000_0000;

    typedef struct packed {
        logic misc_gate;
        logic ext_mem_if_gate;
        logic os_timer_gate;
        logic watchdog_gate;
        logic parallel_port_gate;
        logic serial_uart_gate;
        logic i2c_gate;
        logic ident_module_gate;
        logic gpio_gate;
        logic reserved_gate;
        logic serial_port_b_gate;
        logic serial_port_a_gate;
        logic timer_b_gate;
        logic timer_a_gate;
    } gate_vec_t;

    typedef enum logic [0:0] {
        DOMAIN_ACTIVE = 1'b0,
        DOMAIN_IDLE   = 1'b1
    } domain_state_t;

endpackage
